/* File: debug_pkg.sv */
package debug_pkg;
   // Register select codes on the debug port
   localparam logic [4:0] SEL_STATUS   = 5'h00;
   localparam logic [4:0] SEL_BPCOUNT  = 5'h01;
   localparam logic [4:0] SEL_BPCTRL   = 5'h02;
   localparam logic [4:0] SEL_LIMIT0   = 5'h05;
   localparam logic [4:0] SEL_LIMIT1   = 5'h06;
   localparam logic [4:0] SEL_GDATA    = 5'h09;
   localparam logic [4:0] SEL_TRACE    = 5'h0D;
   localparam logic [4:0] SEL_TAGRING  = 5'h13;
   // Control and status field positions
   localparam int SEQ_LSB   = 10;
   localparam int CC1_LSB   = 8;
   localparam int RW1_LSB   = 6;
   localparam int CC0_LSB   = 4;
   localparam int RW0_LSB   = 2;
   localparam int MBS_LSB   = 0;
   localparam int TME_BIT   = 0;
   localparam int TO_BIT    = 4;
   localparam int MBO_BIT   = 3;
   localparam int OS_LSB    = 6;
   // Reset values
   localparam logic [23:0] CTRL_RST  = 24'h00_0000;
   localparam logic [23:0] COUNT_RST = 24'h00_0000;
   // Encodings
   localparam logic [1:0] CC_NE = 2'h0, CC_EQ = 2'h1, CC_LT = 2'h2, CC_GT = 2'h3;
   localparam logic [1:0] RW_OFF = 2'h0, RW_WR = 2'h1, RW_RD = 2'h2, RW_ANY = 2'h3;
   localparam logic [1:0] MS_P = 2'h1, MS_X = 2'h2, MS_Y = 2'h3;
   localparam logic [1:0] SQ_AND = 2'h0, SQ_OR = 2'h1, SQ_1A0 = 2'h2, SQ_0A1 = 2'h3;
   localparam logic [1:0] OS_RUN = 2'h0, OS_WAIT = 2'h1, OS_BUS = 2'h2, OS_DEBUG = 2'h3;
   localparam int TAG_ENTRIES = 9;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_HALTP = 2'b01,
      ST_DEBUG = 2'b10
   } core_state_t;
endpackage

/* File: debug_breakpoint_trace.sv */
`timescale 1ns/100ps
module debug_breakpoint_trace
   import debug_pkg::*;
#(
   parameter bit ROM_SECURE = 1'b0
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        haltRequestLine_n,
   output logic             haltAckOe,
   input  wire logic        portDebugReq,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [4:0]  regSel,
   input  wire logic [23:0] regWdata,
   output logic [23:0]      regRdata,
   input  wire logic        exitDebug,
   input  wire logic [23:0] progAddr,
   input  wire logic [23:0] xAddr,
   input  wire logic [23:0] yAddr,
   input  wire logic        instrCycle,
   input  wire logic        memRead,
   input  wire logic        memWrite,
   input  wire logic        instrExec,
   input  wire logic        instrLatched,
   input  wire logic        coreWaitStop,
   input  wire logic        coreBusWait,
   input  wire logic        coreGdataWrite,
   input  wire logic [23:0] gdataIn,
   input  wire logic [7:0]  tagValue [8],
   input  wire logic [7:0]  sectorLock,
   input  wire logic [7:0]  sectorLru,
   output logic             wakeCore,
   output logic             haltCore,
   output logic [1:0]       coreStateBits,
   output logic             traceHitFlag,
   output logic [7:0]       replaceSector
);
   //---------------------------------------------
   // Pin synchroniser
   //---------------------------------------------
   logic [2:0] reqSync_q;
   logic       reqPin_q;
   always_ff @(posedge sys_clk) begin
      // No reset: a request held during reset must be seen at release
      reqSync_q <= {reqSync_q[1:0], ~haltRequestLine_n};
      if (reqSync_q[2] == reqSync_q[1]) begin
         reqPin_q <= reqSync_q[2];
      end
   end

   //---------------------------------------------
   // Registers
   //---------------------------------------------
   logic [23:0] breakpointControl_q, breakpointEventCounter_q, traceCountdown_q;
   logic [23:0] limitRegisterZero_q, limitRegisterOne_q, generalDebugData_q;
   logic [23:0] memoryAddressLatch_q;
   logic        traceEnableBit_q, traceHitFlag_q, bpHitFlag_q, armed_q;
   logic        seen0_q, seen1_q;
   logic [3:0]  tagIdx_q;
   core_state_t state_q;
   logic        bpEvent, traceZeroHit, enterDebug, leaveDebug, req;
   logic        inDebug;

   assign inDebug = (state_q == ST_DEBUG);
   // Own acknowledge pulls the shared pin low; mask its echo
   logic [3:0] ackEcho_q;
   always_ff @(posedge sys_clk) begin
      ackEcho_q <= {ackEcho_q[2:0], inDebug};
   end
   assign req = ((reqPin_q & ~inDebug & (ackEcho_q == 4'h0)) | portDebugReq)
                & (armed_q | ~ROM_SECURE);
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         armed_q <= 1'b0;
      end else if (coreGdataWrite) begin
         armed_q <= 1'b1;
      end
   end

   wire ctrlWr = regWrite & inDebug;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         breakpointControl_q <= CTRL_RST;
         limitRegisterZero_q <= COUNT_RST;
         limitRegisterOne_q  <= COUNT_RST;
         traceEnableBit_q    <= 1'b0;
         generalDebugData_q  <= COUNT_RST;
      end else begin
         if (ctrlWr && regSel == SEL_BPCTRL) breakpointControl_q <= {12'h000, regWdata[11:0]};
         if (ctrlWr && regSel == SEL_LIMIT0) limitRegisterZero_q <= regWdata;
         if (ctrlWr && regSel == SEL_LIMIT1) limitRegisterOne_q <= regWdata;
         if (ctrlWr && regSel == SEL_STATUS) traceEnableBit_q <= regWdata[TME_BIT];
         if (coreGdataWrite) generalDebugData_q <= gdataIn;
      end
   end

   //---------------------------------------------
   // Breakpoint compare
   //---------------------------------------------
   wire [1:0] seqF = breakpointControl_q[SEQ_LSB+:2];
   wire [1:0] memory_space_select  = breakpointControl_q[MBS_LSB+:2];
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         memoryAddressLatch_q <= COUNT_RST;
      end else if (instrCycle) begin
         unique case (memory_space_select)
            MS_P:    memoryAddressLatch_q <= progAddr;
            MS_X:    memoryAddressLatch_q <= xAddr;
            MS_Y:    memoryAddressLatch_q <= yAddr;
            default: memoryAddressLatch_q <= memoryAddressLatch_q;
         endcase
      end
   end
   logic accessValid_q;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         accessValid_q <= 1'b0;
      end else begin
         accessValid_q <= instrCycle & (memRead | memWrite) & ~inDebug;
      end
   end
   logic rdQ, wrQ;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdQ <= 1'b0;
         wrQ <= 1'b0;
      end else begin
         rdQ <= memRead;
         wrQ <= memWrite;
      end
   end
   logic [1:0] cmpHit;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cmp
         wire [1:0]  cc  = breakpointControl_q[(g ? CC1_LSB : CC0_LSB)+:2];
         wire [1:0]  rw  = breakpointControl_q[(g ? RW1_LSB : RW0_LSB)+:2];
         wire [23:0] lim = g ? limitRegisterOne_q : limitRegisterZero_q;
         logic c, a;
         always_comb begin
            unique case (cc)
               CC_NE: c = memoryAddressLatch_q != lim;
               CC_EQ: c = memoryAddressLatch_q == lim;
               CC_LT: c = memoryAddressLatch_q < lim;
               CC_GT: c = memoryAddressLatch_q > lim;
            endcase
         end
         always_comb begin
            unique case (rw)
               RW_OFF: a = 1'b0;
               RW_WR:  a = wrQ;
               RW_RD:  a = rdQ;
               RW_ANY: a = rdQ | wrQ;
            endcase
         end
         assign cmpHit[g] = c & a & accessValid_q & (memory_space_select != 2'h0);
      end
   endgenerate

   always_comb begin
      unique case (seqF)
         SQ_AND: bpEvent = cmpHit[0] & cmpHit[1];
         SQ_OR:  bpEvent = cmpHit[0] | cmpHit[1];
         SQ_1A0: bpEvent = cmpHit[1] & seen0_q;
         SQ_0A1: bpEvent = cmpHit[0] & seen1_q;
      endcase
   end
   wire bpCountWr = ctrlWr && regSel == SEL_BPCOUNT;
   always_ff @(posedge sys_clk) begin
      if (reset || bpCountWr || bpEvent) begin
         seen0_q <= 1'b0;
         seen1_q <= 1'b0;
      end else begin
         seen0_q <= seen0_q | cmpHit[0];
         seen1_q <= seen1_q | cmpHit[1];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         breakpointEventCounter_q <= COUNT_RST;
      end else if (bpCountWr) begin
         breakpointEventCounter_q <= regWdata;
      end else if (bpEvent && breakpointEventCounter_q != 24'h00_0000) begin
         breakpointEventCounter_q <= breakpointEventCounter_q - 24'h00_0001;
      end
   end
   wire bpTrip = bpEvent && breakpointEventCounter_q == 24'h00_0000;

   //---------------------------------------------
   // Trace
   //---------------------------------------------
   wire traceWr = ctrlWr && regSel == SEL_TRACE;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         traceCountdown_q <= COUNT_RST;
      end else if (traceWr) begin
         traceCountdown_q <= regWdata;
      end else if (!inDebug && traceEnableBit_q && instrExec
                   && traceCountdown_q != 24'h00_0000) begin
         traceCountdown_q <= traceCountdown_q - 24'h00_0001;
      end
   end
   assign traceZeroHit = !inDebug && traceEnableBit_q && instrExec
                         && traceCountdown_q == 24'h00_0000;

   //---------------------------------------------
   // Debug state
   //---------------------------------------------
   logic resetReq_q;
   always_ff @(posedge sys_clk) begin
      resetReq_q <= reset ? 1'b1 : 1'b0;
   end
   assign enterDebug = (state_q == ST_HALTP && instrLatched) || bpTrip || traceZeroHit;
   assign leaveDebug = inDebug && exitDebug;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= ST_RUN;
      end else begin
         unique case (state_q)
            ST_RUN:   if (bpTrip || traceZeroHit || (resetReq_q && req)) state_q <= ST_DEBUG;
                      else if (req) state_q <= ST_HALTP;
            ST_HALTP: if (enterDebug) state_q <= ST_DEBUG;
            ST_DEBUG: if (exitDebug) state_q <= ST_RUN;
            default:  state_q <= ST_RUN;
         endcase
      end
   end
   // Wake from wait/stop when request pending
   assign wakeCore = (state_q == ST_HALTP) & coreWaitStop;
   assign haltCore = inDebug;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         traceHitFlag_q <= 1'b0;
         bpHitFlag_q    <= 1'b0;
      end else if (leaveDebug) begin
         traceHitFlag_q <= 1'b0;
         bpHitFlag_q    <= 1'b0;
      end else begin
         if (traceZeroHit) traceHitFlag_q <= 1'b1;
         if (bpTrip) bpHitFlag_q <= 1'b1;
      end
   end
   assign traceHitFlag = traceHitFlag_q;
   always_comb begin
      if (inDebug) coreStateBits = OS_DEBUG;
      else if (coreWaitStop) coreStateBits = OS_WAIT;
      else if (coreBusWait) coreStateBits = OS_BUS;
      else coreStateBits = OS_RUN;
   end
   assign haltAckOe = inDebug;

   //---------------------------------------------
   // Cache tag ring
   //---------------------------------------------
   // replaceable sector
   assign replaceSector = sectorLru & ~sectorLock;
   wire tagAcc = (regRead | regWrite) && regSel == SEL_TAGRING && inDebug;
   always_ff @(posedge sys_clk) begin
      if (reset || leaveDebug) begin
         tagIdx_q <= 4'h0;
      end else if (tagAcc) begin
         tagIdx_q <= (tagIdx_q == 4'(TAG_ENTRIES - 1)) ? 4'h0 : tagIdx_q + 4'h1;
      end
   end
   logic [23:0] tagWord;
   always_comb begin
      if (tagIdx_q < 4'h8) tagWord = {16'h0000, tagValue[tagIdx_q[2:0]]};
      else tagWord = {8'h00, sectorLock, sectorLru};
   end

   //---------------------------------------------
   // Read mux
   //---------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regRdata <= COUNT_RST;
      end else if (regRead) begin
         unique case (regSel)
            SEL_STATUS:  regRdata <= {16'h0000, coreStateBits, 1'b0, traceHitFlag_q,
                                      bpHitFlag_q, 2'b00, traceEnableBit_q};
            SEL_BPCOUNT: regRdata <= breakpointEventCounter_q;
            SEL_BPCTRL:  regRdata <= breakpointControl_q;
            SEL_LIMIT0:  regRdata <= limitRegisterZero_q;
            SEL_LIMIT1:  regRdata <= limitRegisterOne_q;
            SEL_GDATA:   regRdata <= generalDebugData_q;
            SEL_TRACE:   regRdata <= traceCountdown_q;
            SEL_TAGRING: regRdata <= tagWord;
            default:     regRdata <= 24'h00_0000;
         endcase
      end
   end

   //---------------------------------------------
   // Checks
   //---------------------------------------------
   a_trace_zero_enters: assert property (@(posedge sys_clk) disable iff (reset)
      traceZeroHit |=> inDebug && traceHitFlag_q) else $error("trace zero no entry");
   a_bp_trip_enters: assert property (@(posedge sys_clk) disable iff (reset)
      bpTrip |=> inDebug) else $error("breakpoint trip missed");
   a_bp_decrement: assert property (@(posedge sys_clk) disable iff (reset)
      bpEvent && !bpCountWr && breakpointEventCounter_q != 0 |=>
      breakpointEventCounter_q == $past(breakpointEventCounter_q) - 1)
      else $error("counter not decremented");
   a_ack_in_debug: assert property (@(posedge sys_clk) disable iff (reset)
      inDebug |-> haltAckOe && coreStateBits == OS_DEBUG) else $error("ack missing");
   a_tag_exit_clear: assert property (@(posedge sys_clk) disable iff (reset)
      leaveDebug |=> tagIdx_q == 0) else $error("tag index not cleared");
   a_tag_wrap: assert property (@(posedge sys_clk) disable iff (reset)
      tagAcc && tagIdx_q == 8 && !leaveDebug |=> tagIdx_q == 0) else $error("tag wrap");
   a_halt_after_latch: assert property (@(posedge sys_clk) disable iff (reset)
      state_q == ST_HALTP && instrLatched |=> inDebug) else $error("no halt");
   a_count_load: assert property (@(posedge sys_clk) disable iff (reset)
      bpCountWr |=> !seen0_q && !seen1_q) else $error("sequence not reset");
   a_trace_hold: assert property (@(posedge sys_clk) disable iff (reset)
      inDebug && !traceWr |=> $stable(traceCountdown_q)) else $error("trace moved");
   c_trace: cover property (@(posedge sys_clk) traceZeroHit);
   c_bp: cover property (@(posedge sys_clk) bpTrip);
   c_req: cover property (@(posedge sys_clk) state_q == ST_HALTP ##[1:20] inDebug);
endmodule // debug_breakpoint_trace

/* File: debug_ctrl_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Far side: debug command controller
// ----------------------------------------
module debug_ctrl_model #(
   parameter int REL_DELAY = 1
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic reqWant,
   input  wire logic haltAckOe,
   output logic      haltRequestLine_n
);
   logic       driveLow_q;
   logic [3:0] ackCnt_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         driveLow_q <= reqWant;
         ackCnt_q   <= 4'h0;
      end else begin
         if (!haltAckOe) ackCnt_q <= 4'h0;
         else if (ackCnt_q != 4'hF) ackCnt_q <= ackCnt_q + 4'h1;
         driveLow_q <= reqWant && !(haltAckOe && ackCnt_q >= 4'(REL_DELAY));
      end
   end

   // Pull-up on the shared open-drain wire
   assign haltRequestLine_n = !(driveLow_q || haltAckOe);
endmodule // debug_ctrl_model

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench
   import debug_pkg::*;
();
   typedef struct {
      logic [11:0] c; logic [1:0] ms; logic [23:0] a1, a2; logic [1:0] rw;
      logic [23:0] n; logic hit;
   } bp_case_t;
   logic sys_clk = 0, reset = 1, reqWant = 1, portDebugReq = 0, regWrite = 0, regRead = 0;
   logic exitDebug = 0, instrCycle = 0, memRead = 0, memWrite = 0, instrExec = 0;
   logic instrLatched = 0, coreWaitStop = 0, coreBusWait = 0, rdLate = 0, coreGdataWrite = 0;
   logic [23:0] gdataIn = 24'h00_0000;
   logic [4:0]  regSel = 5'h00;
   logic [23:0] regWdata = 24'h00_0000, progAddr = 24'h00_0000;
   logic [23:0] xAddr = 24'h00_0000, yAddr = 24'h00_0000, regRdata, d;
   logic [7:0]  tagValue [8] = '{default: 8'h00};
   logic [7:0]  sectorLock = 8'h00, sectorLru = 8'h01, replaceSector;
   logic        haltRequestLine_n, haltAckOe, wakeCore, haltCore, traceHitFlag;
   logic [1:0]  coreStateBits;
   logic [31:0] rng = 32'h0000_c38a;
   logic [23:0] expQ [$];
   bp_case_t    cs [8];
   int          nErrors = 0, totalChecks = 0;

   always #20 sys_clk = ~sys_clk;

   debug_breakpoint_trace #(.ROM_SECURE(1'b0)) uut (
      .sys_clk(sys_clk), .reset(reset), .haltRequestLine_n(haltRequestLine_n),
      .haltAckOe(haltAckOe), .portDebugReq(portDebugReq), .regWrite(regWrite),
      .regRead(regRead), .regSel(regSel), .regWdata(regWdata), .regRdata(regRdata),
      .exitDebug(exitDebug), .progAddr(progAddr), .xAddr(xAddr), .yAddr(yAddr),
      .instrCycle(instrCycle), .memRead(memRead), .memWrite(memWrite),
      .instrExec(instrExec), .instrLatched(instrLatched), .coreWaitStop(coreWaitStop),
      .coreBusWait(coreBusWait), .coreGdataWrite(coreGdataWrite), .gdataIn(gdataIn),
      .tagValue(tagValue), .sectorLock(sectorLock), .sectorLru(sectorLru),
      .wakeCore(wakeCore), .haltCore(haltCore), .coreStateBits(coreStateBits),
      .traceHitFlag(traceHitFlag), .replaceSector(replaceSector));

   debug_ctrl_model #(.REL_DELAY(2)) partner (
      .sys_clk(sys_clk), .reset(reset), .reqWant(reqWant), .haltAckOe(haltAckOe),
      .haltRequestLine_n(haltRequestLine_n));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function logic [23:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[23:0];
   endfunction
   function logic [11:0] mk(logic [1:0] sq, c1, w1, c0, w0, ms);
      return {sq, c1, w1, c0, w0, ms};
   endfunction
   function logic [23:0] entry(int i);
      return (i == 8) ? {8'h00, sectorLock, sectorLru} : {16'h0000, tagValue[i]};
   endfunction
   task wrapUp();
      $display("checks %0d mismatches %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tick();
      @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [4:0] s, input logic [23:0] v);
      regSel = s; regWdata = v; regWrite = 1; tick(); regWrite = 0; tick();
   endtask
   task rd(input logic [4:0] s, input logic [23:0] e);
      regSel = s; regRead = 1; expQ.push_back(e); tick(); regRead = 0; tick();
   endtask
   task waitHalt(input logic e, input int lim);
      for (int i = 0; i < lim && haltCore !== 1'b1; i++) tick();
      if (e && haltCore !== 1'b1) begin
         nErrors++;
         wrapUp();
      end else chk({23'h0, haltCore}, {23'h0, e});
   endtask
   task leave();
      exitDebug = 1; tick(); exitDebug = 0; repeat (6) tick();
   endtask
   task enterReq();
      portDebugReq = 1; tick(); instrLatched = 1; tick(); instrLatched = 0;
      waitHalt(1, 10);
      portDebugReq = 0;
   endtask
   task access(input logic [1:0] ms, input logic [23:0] a, input logic [1:0] rw);
      progAddr = (ms == MS_P) ? a : ~a; xAddr = (ms == MS_X) ? a : ~a;
      yAddr = (ms == MS_Y) ? a : ~a; memRead = rw[1]; memWrite = rw[0];
      instrCycle = 1; tick(); instrCycle = 0; tick(); memRead = 0; memWrite = 0; tick();
   endtask

   // ----------------------------------------
   // Read data monitor
   // ----------------------------------------
   always @(posedge sys_clk) rdLate <= regRead;
   always @(negedge sys_clk) begin
      if (rdLate && expQ.size() > 0) chk(regRdata, expQ.pop_front());
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      cs = '{
         '{mk(SQ_OR, CC_EQ, RW_OFF, CC_EQ, RW_RD, MS_X), MS_X, 24'h00_0050, 24'h00_0100, 2'h2, 0, 1},
         '{mk(SQ_AND, CC_LT, RW_ANY, CC_GT, RW_ANY, MS_Y), MS_Y, 24'h00_0080, 24'h00_0150, 2'h1,
           0, 1},
         '{mk(SQ_1A0, CC_EQ, RW_WR, CC_EQ, RW_WR, MS_P), MS_P, 24'h00_0100, 24'h00_0200, 2'h1,
           0, 1},
         '{mk(SQ_0A1, CC_EQ, RW_WR, CC_EQ, RW_WR, MS_P), MS_P, 24'h00_0100, 24'h00_0200, 2'h1,
           0, 0},
         '{mk(SQ_OR, CC_EQ, RW_OFF, CC_NE, RW_WR, MS_X), MS_X, 24'h00_0300, 24'h00_0100, 2'h2, 0, 0},
         '{mk(SQ_OR, CC_EQ, RW_OFF, CC_NE, RW_ANY, 2'h0), 2'h0, 24'h00_0300, 24'h00_0300, 2'h2,
           0, 0},
         '{mk(SQ_OR, CC_GT, RW_RD, CC_EQ, RW_OFF, MS_P), MS_P, 24'h00_0150, 24'h80_0000, 2'h2, 0, 1},
         '{mk(SQ_OR, CC_EQ, RW_OFF, CC_EQ, RW_RD, MS_X), MS_X, 24'h00_0100, 24'h00_0100, 2'h2, 1, 1}};
      repeat (12) tick();
      reset = 0;
      waitHalt(1, 8);
      chk({23'h0, haltAckOe}, 24'h1);
      reqWant = 0;
      rd(SEL_STATUS, 24'h00_00C0);
      rd(SEL_BPCTRL, 24'h00_0000);
      rd(SEL_BPCOUNT, 24'h00_0000);
      rd(SEL_TRACE, 24'h00_0000);
      rd(5'h03, 24'h00_0000);
      d = rnd(); wr(SEL_BPCOUNT, d); rd(SEL_BPCOUNT, d);
      d = rnd(); wr(SEL_TRACE, d); rd(SEL_TRACE, d);
      // Cache tag ring and replacement
      foreach (tagValue[i]) begin
         d = rnd();
         tagValue[i] = d[7:0];
      end
      d = rnd(); sectorLock = d[7:0]; sectorLru = d[15:8] | 8'h01; tick();
      chk(replaceSector, sectorLru & ~sectorLock);
      for (int i = 0; i < 10; i++) rd(SEL_TAGRING, entry(i % 9));
      d = rnd(); gdataIn = d; coreGdataWrite = 1; tick(); coreGdataWrite = 0;
      rd(SEL_GDATA, d);
      leave();
      chk(coreStateBits, OS_RUN);
      coreBusWait = 1; tick(); chk(coreStateBits, OS_BUS); coreBusWait = 0;
      coreWaitStop = 1; tick(); chk(coreStateBits, OS_WAIT); reqWant = 1;
      for (int i = 0; i < 10 && wakeCore !== 1'b1; i++) tick();
      chk({23'h0, wakeCore}, 24'h1);
      if (wakeCore !== 1'b1) wrapUp();
      coreWaitStop = 0; tick(); instrLatched = 1; tick(); instrLatched = 0;
      waitHalt(1, 10);
      reqWant = 0;
      rd(SEL_TAGRING, entry(0));
      sectorLock = 8'hFF; sectorLru = 8'hFF; tick();
      chk(replaceSector, 8'h00);
      // Breakpoint table
      foreach (cs[i]) begin
         wr(SEL_LIMIT0, 24'h00_0100); wr(SEL_LIMIT1, 24'h00_0200);
         wr(SEL_BPCTRL, {12'h000, cs[i].c}); rd(SEL_BPCTRL, {12'h000, cs[i].c});
         wr(SEL_BPCOUNT, cs[i].n);
         leave();
         access(cs[i].ms, cs[i].a1, cs[i].rw);
         chk({23'h0, haltCore}, 24'h0);
         access(cs[i].ms, cs[i].a2, cs[i].rw);
         waitHalt(cs[i].hit, 4);
         if (!cs[i].hit) enterReq();
         rd(SEL_STATUS, cs[i].hit ? 24'h00_00C8 : 24'h00_00C0);
      end
      // Trace countdown over three instructions
      // load, enable, exit
      wr(SEL_TRACE, 24'h00_0002); wr(SEL_STATUS, 24'h00_0001);
      leave();
      repeat (2) begin
         instrExec = 1; tick(); instrExec = 0; tick();
      end
      chk({23'h0, haltCore}, 24'h0);
      instrExec = 1; tick(); instrExec = 0;
      waitHalt(1, 4);
      chk({23'h0, traceHitFlag}, 24'h1);
      chk(coreStateBits, OS_DEBUG);
      rd(SEL_STATUS, 24'h00_00D1);
      rd(SEL_TRACE, 24'h00_0000);
      repeat (4) tick();
      wrapUp();
   end
endmodule // testbench
